// ==== common/bridge_cfg_consts.svh ====
// Purpose: offsets, field positions and reset values of the bridge header
// Assumes: printed offsets used as word indices; one 32-bit word per register
// Notes:   definitions only
`ifndef BRIDGE_CFG_CONSTS_SVH
`define BRIDGE_CFG_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices (printed offsets), byte address is four times these
// ----------------------------------------------------------------------
`define OFS_STATUS      12'h006
`define OFS_REVISION    12'h008
`define OFS_CLASS       12'h009
`define OFS_CACHE_LINE  12'h00c
`define OFS_COMMAND     12'h004
`define OFS_LOCK        12'h040
`define OFS_IRQ_STATUS  12'h041
`define OFS_IRQ_MASK    12'h042
`define ADDR_W          14

// ----------------------------------------------------------------------
// status and command field positions
// ----------------------------------------------------------------------
`define ST_IRQ_PEND     3
`define ST_CAP_LIST     4
`define ST_SYS_ERR      14
`define ST_POISON       15
`define CMD_SERR_EN     8
`define CMD_PERR_EN     6

// ----------------------------------------------------------------------
// constant field values
// ----------------------------------------------------------------------
`define CLASS_BASE      8'h06
`define CLASS_SUB       8'h04
`define CLASS_PROG_IF   8'h00
`define CACHE_LINE_RST  8'h00
// arbitrary neutral revision value, not taken from any real part
`define REVISION_RST    8'h5a
`define IRQ_EVENTS      3
`define EV_SYS_ERR      0
`define EV_POISON       1
`define EV_IRQ_PEND     2

`endif

// ==== common/bridge_cfg_pkg.sv ====
// Purpose: types of the bridge header block
// Assumes: constants live in bridge_cfg_consts.svh
// Notes:   port role selects the interrupt-pending source
package bridge_cfg_pkg;
  typedef enum logic [1:0] {
    PORT_UPSTREAM   = 2'b01,
    PORT_DOWNSTREAM = 2'b10
  } port_role_e;
endpackage

// ==== src/bridge_config_status_header.sv ====
// Purpose: status, revision, class code and cache line size of a bridge
// Assumes: config port with read data one cycle after read strobe
// Notes:   extra command, lock and event registers sit at 0x004, 0x040-42
//
// Operation
// RULE1: pending bit follows own legacy interrupt
// RULE2: forwarded downstream interrupts never set pending
// RULE3: downstream port: hot-plug interrupt sets pending
// RULE4: upstream port: unmasked memory error sets pending
// RULE5: capability list bit reads constant one
// RULE6: sent target abort reads zero always
// RULE7: legacy status bits read constant zero
// RULE8: error message with enable sets system error
// RULE9: poisoned packet sets parity bit unconditionally
// RULE10: eight-bit revision, writable until locked
// RULE11: class code base 0x06, sub 0x04
// RULE12: interface byte: no subtractive decode
// RULE13: cache line size read-write, reset zero
// RULE14: command bit 8 enables system error
// RULE15: read-only ignore writes; zero leaves sticky
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "bridge_cfg_consts.svh"

module bridge_config_status_header
  import bridge_cfg_pkg::*;
#(
  parameter port_role_e PORT_ROLE = PORT_DOWNSTREAM
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                clock_en,
  // register port
  input  wire logic [`ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [31:0]         reg_rdata,
  // event sources, same clock domain
  input  wire logic                hotplug_irq,
  input  wire logic                mem_error,
  input  wire logic                mem_error_mask,
  input  wire logic                forwarded_irq,
  input  wire logic                error_msg_sent,
  input  wire logic                poisoned_tlp,
  // outputs
  output logic                     legacy_irq_pending,
  output logic                     system_error_report_enable,
  output logic                     irq
);

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  function automatic logic hit(input logic [`ADDR_W-1:0] a,
                               input logic [11:0] idx);
    hit = (a[`ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // sticky bit update: a set in the same cycle beats the clear
  function automatic logic w1c_next(input logic set,
                                    input logic cur,
                                    input logic clr);
    w1c_next = set | (cur & ~clr);
  endfunction

  wire logic sel_status = hit(reg_addr, `OFS_STATUS);
  wire logic sel_rev    = hit(reg_addr, `OFS_REVISION);
  wire logic sel_class  = hit(reg_addr, `OFS_CLASS);
  wire logic sel_cls    = hit(reg_addr, `OFS_CACHE_LINE);
  wire logic sel_cmd    = hit(reg_addr, `OFS_COMMAND);
  wire logic sel_lock   = hit(reg_addr, `OFS_LOCK);
  wire logic sel_ist    = hit(reg_addr, `OFS_IRQ_STATUS);
  wire logic sel_imask  = hit(reg_addr, `OFS_IRQ_MASK);

  wire logic wr_status = clock_en & reg_write & sel_status;
  wire logic wr_rev    = clock_en & reg_write & sel_rev;
  wire logic wr_cls    = clock_en & reg_write & sel_cls;
  wire logic wr_cmd    = clock_en & reg_write & sel_cmd;
  wire logic wr_lock   = clock_en & reg_write & sel_lock;
  wire logic wr_ist    = clock_en & reg_write & sel_ist;
  wire logic wr_imask  = clock_en & reg_write & sel_imask;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic                    sys_err_reg;
  logic                    poison_reg;
  logic                    pending_reg;
  logic [7:0]              revision_number_reg;
  logic                    lock_reg;
  logic [7:0]              cache_line_length_reg;
  logic                    serr_en_reg;
  logic                    perr_en_reg;
  logic [`IRQ_EVENTS-1:0]  ev_status_reg;
  logic [`IRQ_EVENTS-1:0]  ev_mask_reg;
  logic                    pend_prev_reg;
  logic [31:0]             rdata_reg;

  // --------------------------------------------------------------------
  // event sources
  // --------------------------------------------------------------------
  // only port-originated sources; forwarded_irq is deliberately unused
  wire logic pending_next =
    (PORT_ROLE == PORT_DOWNSTREAM) ? hotplug_irq       // see RULE3
                                   : (mem_error & ~mem_error_mask); // see RULE4
  wire logic sys_err_set = error_msg_sent & serr_en_reg;  // see RULE8
  wire logic poison_set  = poisoned_tlp;  // see RULE9

  wire logic [`IRQ_EVENTS-1:0] ev_set;
  assign ev_set[`EV_SYS_ERR]  = sys_err_set;
  assign ev_set[`EV_POISON]   = poison_set;
  assign ev_set[`EV_IRQ_PEND] = pending_next & ~pend_prev_reg;

  wire logic [`IRQ_EVENTS-1:0] ev_clr =
    wr_ist ? reg_wdata[`IRQ_EVENTS-1:0] : '0;

  // --------------------------------------------------------------------
  // status word view
  // --------------------------------------------------------------------
  // parallel-bus fields mean nothing on a serial link, so tie them off
  wire logic       fast_clock_capable       = 1'b0;   // see RULE7
  wire logic       back_to_back_capable     = 1'b0;   // see RULE7
  wire logic       master_parity_error_seen = 1'b0;   // see RULE7
  wire logic [1:0] select_timing            = 2'b00;  // see RULE7
  wire logic       sent_target_abort        = 1'b0;   // see RULE6
  wire logic       got_target_abort         = 1'b0;   // see RULE7
  wire logic       got_master_abort         = 1'b0;   // see RULE7
  wire logic       capability_list_present  = 1'b1;   // see RULE5
  wire logic [7:0] programming_interface    = `CLASS_PROG_IF;  // see RULE12

  // reserved bits read zero; writes never reach the constant fields
  wire logic [15:0] status_word = {
    poison_reg,                  // 15
    sys_err_reg,                 // 14
    got_master_abort,            // 13
    got_target_abort,            // 12
    sent_target_abort,           // 11
    select_timing,               // 10:9
    master_parity_error_seen,    // 8
    back_to_back_capable,        // 7
    1'b0,                        // 6 reserved
    fast_clock_capable,          // 5
    capability_list_present,     // 4
    pending_reg,                 // 3 see RULE1
    3'b000                       // 2:0 reserved
  };

  wire logic [15:0] cmd_word =
    (16'h0001 << `CMD_SERR_EN) & {16{serr_en_reg}} |
    (16'h0001 << `CMD_PERR_EN) & {16{perr_en_reg}};

  wire logic [23:0] class_word =
    {`CLASS_BASE, `CLASS_SUB, programming_interface};  // see RULE11

  wire logic [31:0] rd_mux =
    sel_status ? {16'h0000, status_word} :
    sel_rev    ? {24'h000000, revision_number_reg} :
    sel_class  ? {8'h00, class_word} :
    sel_cls    ? {24'h000000, cache_line_length_reg} :
    sel_cmd    ? {16'h0000, cmd_word} :
    sel_lock   ? {31'h00000000, lock_reg} :
    sel_ist    ? {29'h00000000, ev_status_reg} :
    sel_imask  ? {29'h00000000, ev_mask_reg} :
                 32'h00000000;

  // --------------------------------------------------------------------
  // sticky status bits: set wins over write-one clear
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sys_err_reg <= 1'b0;
      poison_reg  <= 1'b0;
    end else if (clock_en) begin
      // zero writes and read-only bits leave state alone, see RULE15
      sys_err_reg <= w1c_next(sys_err_set, sys_err_reg,
                              wr_status & reg_wdata[`ST_SYS_ERR]);  // see RULE8
      poison_reg  <= w1c_next(poison_set, poison_reg,
                              wr_status & reg_wdata[`ST_POISON]);   // see RULE9
    end
  end

  // pending tracks the source level, not sticky
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pending_reg   <= 1'b0;
      pend_prev_reg <= 1'b0;
    end else if (clock_en) begin
      pending_reg   <= pending_next;  // see RULE1 see RULE2
      pend_prev_reg <= pending_next;
    end
  end

  // --------------------------------------------------------------------
  // writable fields
  // --------------------------------------------------------------------
  // revision resets to a plain value; lock freezes it until reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      revision_number_reg <= `REVISION_RST;
      lock_reg            <= 1'b0;
    end else begin
      if (wr_rev && !lock_reg) begin
        revision_number_reg <= reg_wdata[7:0];  // see RULE10
      end
      if (wr_lock && reg_wdata[0]) begin
        lock_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cache_line_length_reg <= `CACHE_LINE_RST;
    end else if (wr_cls) begin
      cache_line_length_reg <= reg_wdata[7:0];  // see RULE13
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serr_en_reg <= 1'b0;
      perr_en_reg <= 1'b0;
    end else if (wr_cmd) begin
      serr_en_reg <= reg_wdata[`CMD_SERR_EN];  // see RULE14
      perr_en_reg <= reg_wdata[`CMD_PERR_EN];
    end
  end

  // --------------------------------------------------------------------
  // interrupt status and mask
  // --------------------------------------------------------------------
  // a new event in the clearing cycle stays recorded
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ev_status_reg <= '0;
    end else if (clock_en) begin
      ev_status_reg <= ev_set | (ev_status_reg & ~ev_clr);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ev_mask_reg <= '0;
    end else if (wr_imask) begin
      ev_mask_reg <= reg_wdata[`IRQ_EVENTS-1:0];
    end
  end

  // --------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------
  // irq lags the status register by one cycle so it comes from a flop
  // read data stands one cycle only, zero otherwise
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h00000000;
    end else if (clock_en) begin
      rdata_reg <= reg_read ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else if (clock_en) begin
      irq <= |(ev_status_reg & ev_mask_reg);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      legacy_irq_pending <= 1'b0;
    end else if (clock_en) begin
      legacy_irq_pending <= pending_next;  // see RULE1
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      system_error_report_enable <= 1'b0;
    end else if (clock_en) begin
      system_error_report_enable <= serr_en_reg;  // see RULE14
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// ==== testbench/bridge_header_properties.sv ====
// Purpose: port assertions of the bridge header
// Assumes: clock_en high whenever a rule is judged
// Notes:   bound into every instance of the header
`timescale 1ns/100ps
module bridge_header_checker
  import bridge_cfg_pkg::*;
#(
  parameter port_role_e PORT_ROLE = PORT_DOWNSTREAM
) (
  // clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        clock_en,
  // register port
  input wire logic [13:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  // events and outputs
  input wire logic        hotplug_irq,
  input wire logic        mem_error,
  input wire logic        mem_error_mask,
  input wire logic        poisoned_tlp,
  input wire logic        legacy_irq_pending
);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire own_irq = (PORT_ROLE == PORT_UPSTREAM) ?
                 mem_error && !mem_error_mask : hotplug_irq;
  sequence rd_at(logic [13:0] a);
    clock_en && reg_read && reg_addr == a;
  endsequence
  sequence wr_at(logic [13:0] a);
    clock_en && reg_write && reg_addr == a;
  endsequence
  cap_list_a: assert property (
    rd_at(14'h018) |=> reg_rdata[4]) else $error("capability bit low");
  abort_zero_a: assert property (
    rd_at(14'h018) |=> !reg_rdata[11]) else $error("target abort set");
  legacy_zero_a: assert property (
    rd_at(14'h018) |=> reg_rdata[13:12] == 2'h0 && reg_rdata[10:5] == 6'h00)
    else $error("legacy status bit set");
  pending_src_a: assert property (
    clock_en |=> legacy_irq_pending == $past(own_irq))
    else $error("pending bit not following source");
  class_code_a: assert property (
    rd_at(14'h024) |=> reg_rdata == 32'h00060400) else $error("class code");
  poison_sets_a: assert property (
    clock_en && poisoned_tlp ##1 rd_at(14'h018) |=> reg_rdata[15])
    else $error("poisoned packet not recorded");
  cache_keep_a: assert property (
    wr_at(14'h030) ##1 rd_at(14'h030) |=>
    reg_rdata[7:0] == $past(reg_wdata[7:0], 2)) else $error("cache line lost");
  clear_hold_a: assert property (
    wr_at(14'h018) ##0 (reg_wdata[15] && !poisoned_tlp) ##1 rd_at(14'h018)
    |=> !reg_rdata[15]) else $error("poison bit not cleared");
endmodule
bind bridge_config_status_header bridge_header_checker #(
  .PORT_ROLE(PORT_ROLE)) chk (.clock(clock), .resetn(resetn),
  .clock_en(clock_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .hotplug_irq(hotplug_irq), .mem_error(mem_error),
  .mem_error_mask(mem_error_mask), .poisoned_tlp(poisoned_tlp),
  .legacy_irq_pending(legacy_irq_pending));

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench of the bridge header
// Assumes: downstream role, clock_en held high
// Notes:   reads are judged from a queue of expected words
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------
  // stimulus and checking
  // ----------------------------------------
  typedef struct {logic [31:0] v; logic [31:0] m; logic [13:0] a;} note_s;
  logic        clock = 0, resetn = 0, reg_write = 0, reg_read = 0;
  logic        rd_seen = 0, hotplug_irq = 0, mem_error = 0;
  logic        mem_error_mask = 0, forwarded_irq = 0;
  logic        error_msg_sent = 0, poisoned_tlp = 0;
  logic [13:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic        legacy_irq_pending, system_error_report_enable, irq;
  logic [7:0]  v;
  note_s       notes[$], note;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  bridge_config_status_header uut (
    .clock(clock), .resetn(resetn), .clock_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .hotplug_irq(hotplug_irq),
    .mem_error(mem_error), .mem_error_mask(mem_error_mask),
    .forwarded_irq(forwarded_irq), .error_msg_sent(error_msg_sent),
    .poisoned_tlp(poisoned_tlp), .legacy_irq_pending(legacy_irq_pending),
    .system_error_report_enable(system_error_report_enable), .irq(irq));
  always #12.5 clock = ~clock;
  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one bus cycle; strobes stay until the next call so none is set twice
  task automatic bus(logic w, logic r, logic [13:0] a, logic [31:0] d);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask
  task automatic rd(logic [13:0] a, logic [31:0] e, logic [31:0] m = '1);
    notes.push_back('{e, m, a});
    bus(0, 1, a, 0);
  endtask
  task automatic pulse(logic [1:0] k);
    bus(0, 0, 0, 0);
    {error_msg_sent, poisoned_tlp} <= k;
    @(posedge clock);
    {error_msg_sent, poisoned_tlp} <= 2'b00;
  endtask
  // forwarded interrupts toggle all run long and must never show
  always @(posedge clock) begin
    {mem_error, mem_error_mask, forwarded_irq} <= 3'($urandom);
    rd_seen <= reg_read;
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
  always @(negedge clock) begin
    if (rd_seen) begin
      note = notes.pop_front();
      check(reg_rdata & note.m, note.v, $sformatf("rdata %h", note.a));
    end
  end
  initial begin
    void'($urandom(32'hc55f969c));
    repeat (12) @(posedge clock);
    resetn <= 1;
    @(posedge clock);
    rd(14'h018, 32'h10);
    rd(14'h020, 32'h5a);
    rd(14'h024, 32'h60400);
    rd(14'h030, 32'h0);
    rd(14'h010, 32'h0);
    bus(1, 0, 14'h018, 32'hffffffff);
    rd(14'h018, 32'h10);
    repeat (4) begin
      v = 8'($urandom);
      bus(1, 0, 14'h030, {24'h0, v});
      rd(14'h030, {24'h0, v});
      bus(1, 0, 14'h020, {24'h0, ~v});
      rd(14'h020, {24'h0, ~v});
    end
    bus(1, 0, 14'h100, 32'h1);
    bus(1, 0, 14'h020, {24'h0, v});
    rd(14'h020, {24'h0, ~v});
    hotplug_irq <= 1;
    repeat (2) bus(0, 0, 0, 0);
    rd(14'h018, 32'h8, 32'h8);
    hotplug_irq <= 0;
    repeat (2) bus(0, 0, 0, 0);
    rd(14'h018, 32'h0, 32'h8);
    pulse(2'b11);
    rd(14'h018, 32'h8010);
    bus(1, 0, 14'h018, 32'h0);
    rd(14'h018, 32'h8010);
    bus(1, 0, 14'h010, 32'h100);
    rd(14'h010, 32'h100, 32'h100);
    #1 check(system_error_report_enable, 1, "report enable");
    pulse(2'b10);
    rd(14'h018, 32'hc010);
    bus(1, 0, 14'h018, 32'h4000);
    rd(14'h018, 32'h8010);
    bus(1, 0, 14'h018, 32'h8000);
    rd(14'h018, 32'h0010);
    bus(1, 0, 14'h108, 32'h2);
    repeat (2) bus(0, 0, 0, 0);
    #1 check(irq, 1, "irq");
    bus(1, 0, 14'h108, 32'h0);
    repeat (2) bus(0, 0, 0, 0);
    #1 check(irq, 0, "masked irq");
    bus(1, 0, 14'h104, 32'h7);
    rd(14'h104, 32'h0, 32'h7);
    rd(14'h3ffc, 32'h0);
    rd(14'h019, 32'h0);
    bus(0, 0, 0, 0);
    repeat (2) @(posedge clock);
    close_out();
  end
endmodule
